// >>> hdl/hbsc_pkg.sv
// Types for the half-bridge SPI control block
package hbsc_pkg;
  typedef enum logic [1:0]
  {
    HBSC_OFF   = 2'b00,
    HBSC_OC    = 2'b01,
    HBSC_UL    = 2'b10,
    HBSC_ON    = 2'b11
  } hbsc_status_e;

  typedef enum logic [1:0]
  {
    HBSC_SLEEP = 2'b00,
    HBSC_POR   = 2'b01,
    HBSC_RUN   = 2'b10
  } hbsc_power_e;
endpackage : hbsc_pkg

// >>> hdl/hbsc_regs.svh
// Constants for the half-bridge SPI control block
`ifndef HBSC_REGS_SVH
`define HBSC_REGS_SVH

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define HBSC_CMD_W          16
`define HBSC_CMD_RESET      16'h0000
`define HBSC_BIT_CLEAR      15
`define HBSC_BIT_GROUP_SEL  14
`define HBSC_BIT_UL_CTRL    13
`define HBSC_EN_LSB         7
`define HBSC_SIDE_LSB       1
`define HBSC_BIT_OV_CTRL    0
`define HBSC_NUM_BRIDGES    6

// ----------------------------------------------------------------
// Frame length and timing
// ----------------------------------------------------------------
`define HBSC_FIRST_BITS     16
`define HBSC_GROUP_BITS     8
`define HBSC_CLK_NS         25
`define HBSC_CLR_GAP_US     150
`define HBSC_CLR_GAP_CYC    ((`HBSC_CLR_GAP_US * 1000 + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)
`define HBSC_POR_US         100
`define HBSC_POR_CYC        ((`HBSC_POR_US * 1000) / `HBSC_CLK_NS)

// ----------------------------------------------------------------
// Bridge status codes
// ----------------------------------------------------------------
`define HBSC_ST_OFF         2'h0
`define HBSC_ST_OC          2'h1
`define HBSC_ST_UL          2'h2
`define HBSC_ST_ON          2'h3

`endif

// >>> hdl/hbsc_spi_ctrl.sv
// SPI command slave and bridge control of the hex half-bridge driver
`timescale 1ns/1ps
`default_nettype none
`include "hbsc_regs.svh"

// Behaviour
// - Command shifted in MSB first
// - Input sampled on falling clock edge
// - Previous diagnostics shifted out on rising edge
// - Fewer than sixteen bits is frame error
// - Extra bits only in groups of eight
// - Select rise loads last sixteen bits
// - Serial output undriven while select high
// - Enable low sleeps and clears everything
// - Enable rise runs power-on reset first
// - Extra pre-frame bit on serial output
// - Bit fifteen clears latched faults
// - Bit thirteen gates under-load shutdown
// - Bits twelve to seven enable bridges
// - Bits six to one select side
// - Bit zero gates overvoltage lockout
// - Priority-encoded two-bit status per bridge
// - Thermal flag OR serial input shown until first rising edge
// - Clear ignored when frames too close
// - Never both sides of a bridge on
module hbsc_spi_ctrl
  import hbsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Serial link pins
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output var  logic        sdo,
  output var  logic        sdo_oe,
  // Enable pin
  input  wire logic        enable,
  // Fault inputs from the power stage
  input  wire logic        thermal_shutdown_in,
  input  wire logic        supply_fault_in,
  input  wire logic        thermal_warning_in,
  input  wire logic [5:0]  overcurrent_in,
  input  wire logic [5:0]  underload_in,
  // Bridge drive outputs
  output var  logic [5:0]  high_side_on,
  output var  logic [5:0]  low_side_on,
  output var  logic        underload_shutdown_ctrl,
  output var  logic        overvoltage_lockout_ctrl,
  output var  logic        awake
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] next_sync1;
  logic [3:0] next_sync2;
  logic [3:0] next_sync3;

  always_comb
  begin
    next_sync1 = {enable, sdi, sclk, select_n};
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 4'h1;
      sync2 <= 4'h1;
      sync3 <= 4'h1;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  logic cs_n;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic din;
  logic en_s;
  assign cs_n     = sync2[0];
  assign cs_fall  = sync3[0] && !sync2[0];
  assign cs_rise  = !sync3[0] && sync2[0];
  assign sck_rise = !sync3[1] && sync2[1] && !cs_n;
  assign sck_fall = sync3[1] && !sync2[1] && !cs_n;
  assign din      = sync2[2];
  assign en_s     = sync2[3];

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  hbsc_power_e power;
  hbsc_power_e next_power;
  logic [11:0] por_cnt;
  logic [11:0] next_por_cnt;
  logic        wipe;

  always_comb
  begin
    next_power   = power;
    next_por_cnt = por_cnt;
    case (power)
      HBSC_SLEEP:
        if (en_s)
        begin
          next_power   = HBSC_POR;
          next_por_cnt = 12'h000;
        end
      HBSC_POR:
        if (!en_s)
          next_power = HBSC_SLEEP;
        else if (por_cnt == 12'(`HBSC_POR_CYC - 1))
          next_power = HBSC_RUN;
        else
          next_por_cnt = por_cnt + 12'h001;
      default:
        if (!en_s)
          next_power = HBSC_SLEEP;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      power   <= HBSC_SLEEP;
      por_cnt <= 12'h000;
    end
    else
    begin
      power   <= next_power;
      por_cnt <= next_por_cnt;
    end
  end

  assign wipe = (power != HBSC_RUN);

  // ----------------------------------------------------------------
  // Status encoder
  // ----------------------------------------------------------------
  hbsc_status_if st ();
  logic [`HBSC_CMD_W-1:0] cmd;
  logic                   clear_pulse;
  logic                   tsd_latch;

  assign st.enable   = cmd[`HBSC_EN_LSB +: 6];
  assign st.oc_fault = overcurrent_in & cmd[`HBSC_EN_LSB +: 6];
  assign st.ul_fault = underload_in;
  assign st.clear    = clear_pulse;
  assign st.wipe     = wipe;

  hbsc_status_enc u_enc
  (
    .clk    (clk),
    .resetn (resetn),
    .st     (st)
  );

  // ----------------------------------------------------------------
  // Serial shift engine
  // ----------------------------------------------------------------
  logic [`HBSC_CMD_W-1:0] rx;
  logic [`HBSC_CMD_W-1:0] tx;
  logic [4:0]             bit_cnt;
  logic                   frame_err;
  logic                   head_done;
  logic                   out_bit;
  logic                   pre_phase;
  logic [`HBSC_CMD_W-1:0] next_rx;
  logic [`HBSC_CMD_W-1:0] next_tx;
  logic [4:0]             next_bit_cnt;
  logic                   next_frame_err;
  logic                   next_head_done;
  logic                   next_out_bit;
  logic                   next_pre_phase;
  logic [`HBSC_CMD_W-1:0] diag;
  logic                   frame_ok;

  assign diag = {st.oc_any, supply_fault_in, st.ul_any, st.code, thermal_warning_in};
  assign frame_ok = !frame_err && head_done && (bit_cnt == 5'h00);

  always_comb
  begin
    next_rx        = rx;
    next_tx        = tx;
    next_bit_cnt   = bit_cnt;
    next_frame_err = frame_err;
    next_head_done = head_done;
    next_out_bit   = out_bit;
    next_pre_phase = pre_phase;
    if (cs_fall)
    begin
      next_tx        = diag;
      next_bit_cnt   = 5'h00;
      next_frame_err = 1'b0;
      next_head_done = 1'b0;
      next_pre_phase = 1'b1;
      next_out_bit   = tsd_latch;
    end
    else if (sck_rise)
    begin
      next_pre_phase = 1'b0;
      next_out_bit   = tx[`HBSC_CMD_W-1];
      next_tx        = {tx[`HBSC_CMD_W-2:0], din};
    end
    else if (sck_fall)
    begin
      next_rx = {rx[`HBSC_CMD_W-2:0], din};
      if (!head_done && bit_cnt == 5'(`HBSC_FIRST_BITS - 1))
      begin
        next_head_done = 1'b1;
        next_bit_cnt   = 5'h00;
      end
      else if (head_done && bit_cnt == 5'(`HBSC_GROUP_BITS - 1))
        next_bit_cnt = 5'h00;
      else
        next_bit_cnt = bit_cnt + 5'h01;
    end
    if (pre_phase && !cs_n && !sck_rise)
      next_out_bit = tsd_latch | din;
    if (wipe)
    begin
      next_rx        = `HBSC_CMD_RESET;
      next_frame_err = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx        <= `HBSC_CMD_RESET;
      tx        <= `HBSC_CMD_RESET;
      bit_cnt   <= 5'h00;
      frame_err <= 1'b0;
      head_done <= 1'b0;
      out_bit   <= 1'b0;
      pre_phase <= 1'b0;
    end
    else
    begin
      rx        <= next_rx;
      tx        <= next_tx;
      bit_cnt   <= next_bit_cnt;
      frame_err <= next_frame_err;
      head_done <= next_head_done;
      out_bit   <= next_out_bit;
      pre_phase <= next_pre_phase;
    end
  end

  // ----------------------------------------------------------------
  // Command register, fault clear and spacing timer
  // ----------------------------------------------------------------
  logic [`HBSC_CMD_W-1:0] next_cmd;
  logic                   next_clear_pulse;
  logic                   next_tsd_latch;
  logic [12:0]            gap_cnt;
  logic [12:0]            next_gap_cnt;
  logic                   gap_met;

  assign gap_met = (gap_cnt == 13'(`HBSC_CLR_GAP_CYC));

  always_comb
  begin
    next_cmd         = cmd;
    next_clear_pulse = 1'b0;
    next_tsd_latch   = tsd_latch | thermal_shutdown_in;
    next_gap_cnt     = gap_met ? gap_cnt : gap_cnt + 13'h0001;
    if (cs_rise)
    begin
      next_gap_cnt = 13'h0000;
      if (frame_ok)
      begin
        next_cmd = rx;
        if (rx[`HBSC_BIT_CLEAR] && gap_met)
          next_clear_pulse = 1'b1;
      end
    end
    if (clear_pulse && !thermal_shutdown_in)
      next_tsd_latch = 1'b0;
    if (wipe)
    begin
      next_cmd         = `HBSC_CMD_RESET;
      next_tsd_latch   = 1'b0;
      next_clear_pulse = 1'b0;
      next_gap_cnt     = 13'(`HBSC_CLR_GAP_CYC);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd         <= `HBSC_CMD_RESET;
      clear_pulse <= 1'b0;
      tsd_latch   <= 1'b0;
      gap_cnt     <= 13'(`HBSC_CLR_GAP_CYC);
    end
    else
    begin
      cmd         <= next_cmd;
      clear_pulse <= next_clear_pulse;
      tsd_latch   <= next_tsd_latch;
      gap_cnt     <= next_gap_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Bridge drive and pin outputs
  // ----------------------------------------------------------------
  logic [5:0] next_hs;
  logic [5:0] next_ls;
  logic [5:0] en_bits;
  logic [5:0] side_bits;
  logic [5:0] block_bits;

  assign en_bits    = cmd[`HBSC_EN_LSB +: 6];
  assign side_bits  = cmd[`HBSC_SIDE_LSB +: 6];

  genvar b;
  generate
    for (b = 0; b < `HBSC_NUM_BRIDGES; b++)
    begin : g_blk
      assign block_bits[b] = (st.code[2*b+1:2*b] == `HBSC_ST_OC)
                          || (cmd[`HBSC_BIT_UL_CTRL]
                              && st.code[2*b+1:2*b] == `HBSC_ST_UL);
    end
  endgenerate

  always_comb
  begin
    next_hs = en_bits & ~block_bits & side_bits;
    next_ls = en_bits & ~block_bits & ~side_bits;
    if (tsd_latch || wipe)
    begin
      next_hs = 6'h00;
      next_ls = 6'h00;
    end
    next_ls = next_ls & ~next_hs & ~high_side_on;
    next_hs = next_hs & ~low_side_on;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_side_on             <= 6'h00;
      low_side_on              <= 6'h00;
      underload_shutdown_ctrl  <= 1'b0;
      overvoltage_lockout_ctrl <= 1'b0;
      awake                    <= 1'b0;
      sdo                      <= 1'b0;
      sdo_oe                   <= 1'b0;
    end
    else
    begin
      high_side_on             <= next_hs;
      low_side_on              <= next_ls;
      underload_shutdown_ctrl  <= cmd[`HBSC_BIT_UL_CTRL];
      overvoltage_lockout_ctrl <= cmd[`HBSC_BIT_OV_CTRL];
      awake                    <= !wipe;
      sdo                      <= next_out_bit;
      sdo_oe                   <= !cs_n && !wipe;
    end
  end
endmodule // hbsc_spi_ctrl
`default_nettype wire

// >>> hdl/hbsc_status_enc.sv
// Per-bridge priority status encoder
`timescale 1ns/1ps
`default_nettype none
`include "hbsc_regs.svh"
module hbsc_status_enc
  import hbsc_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   resetn,
  // Status link
  hbsc_status_if.enc  st
);
  hbsc_status_e state      [`HBSC_NUM_BRIDGES];
  hbsc_status_e next_state [`HBSC_NUM_BRIDGES];
  logic [5:0]   oc_bits;
  logic [5:0]   ul_bits;

  // ----------------------------------------------------------------
  // Priority state per bridge
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `HBSC_NUM_BRIDGES; g++)
    begin : g_br
      always_comb
      begin
        next_state[g] = state[g];
        case (state[g])
          HBSC_OC:
            if (st.clear && !st.oc_fault[g])
              next_state[g] = st.enable[g] ? HBSC_ON : HBSC_OFF;
          HBSC_UL:
            if (st.oc_fault[g])
              next_state[g] = HBSC_OC;
            else if (st.clear && !st.ul_fault[g])
              next_state[g] = st.enable[g] ? HBSC_ON : HBSC_OFF;
          default:
            if (st.oc_fault[g])
              next_state[g] = HBSC_OC;
            else if (st.ul_fault[g] && st.enable[g])
              next_state[g] = HBSC_UL;
            else
              next_state[g] = st.enable[g] ? HBSC_ON : HBSC_OFF;
        endcase
        if (st.wipe)
          next_state[g] = HBSC_OFF;
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          state[g] <= HBSC_OFF;
        else
          state[g] <= next_state[g];
      end

      assign st.code[2*g+1:2*g] = state[g];
      assign oc_bits[g] = (state[g] == HBSC_OC);
      assign ul_bits[g] = (state[g] == HBSC_UL);
    end
  endgenerate

  assign st.oc_any = |oc_bits;
  assign st.ul_any = |ul_bits;
endmodule // hbsc_status_enc
`default_nettype wire

// >>> hdl/hbsc_status_if.sv
// Interface between control core and status encoder
`timescale 1ns/1ps
`default_nettype none
interface hbsc_status_if;
  logic [5:0]  enable;
  logic [5:0]  oc_fault;
  logic [5:0]  ul_fault;
  logic        clear;
  logic        wipe;
  logic [11:0] code;
  logic        oc_any;
  logic        ul_any;
  modport core (output enable, oc_fault, ul_fault, clear, wipe, input code, oc_any, ul_any);
  modport enc  (input enable, oc_fault, ul_fault, clear, wipe, output code, oc_any, ul_any);
endinterface : hbsc_status_if
`default_nettype wire

// >>> verif/hbsc_chk.sv
// Assertion checker for the half-bridge SPI control block
`timescale 1ns/1ps
`default_nettype none
module hbsc_chk
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Watched pins
  input wire logic       select_n,
  input wire logic       sclk,
  input wire logic       enable,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic [5:0] high_side_on,
  input wire logic [5:0] low_side_on,
  input wire logic       underload_shutdown_ctrl,
  input wire logic       overvoltage_lockout_ctrl,
  input wire logic       awake
);
  logic [12:0] en_cnt;
  logic [12:0] next_en_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Enable-high cycle counter
  // ----------------------------------------------------------------
  always_comb
  begin
    next_en_cnt = en_cnt + {12'h0, en_cnt != 13'h1fff};
    if (!enable)
      next_en_cnt = 13'h0;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      en_cnt <= 13'h0;
    else
      en_cnt <= next_en_cnt;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_no_overlap; (high_side_on & low_side_on) == 6'h0; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both sides on");
  property p_dead; ((high_side_on & $past(low_side_on)) |
    (low_side_on & $past(high_side_on))) == 6'h0; endproperty
  a_dead: assert property (p_dead) else $error("no dead cycle");
  property p_oe_off; select_n [*6] |-> !sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
  property p_oe_on; $fell(select_n) && awake |-> ##[2:6] sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not enabled");
  property p_sleep; (!enable) [*6] |-> !awake && !sdo_oe && high_side_on == 6'h0 &&
    low_side_on == 6'h0 && !underload_shutdown_ctrl && !overvoltage_lockout_ctrl; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not cleared");
  property p_wake_drop; $fell(enable) |-> ##[1:5] !awake; endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("awake kept");
  property p_por; $rose(awake) |-> en_cnt >= 13'hf9e; endproperty
  a_por: assert property (p_por) else $error("power-on wait short");
  property p_ctrl_stable; (enable && select_n) [*8] |=>
    $stable({underload_shutdown_ctrl, overvoltage_lockout_ctrl}); endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("ctrl moved");
  property p_sdo_stable; (!select_n && $stable(sclk)) [*6] |=> $stable(sdo); endproperty
  a_sdo_stable: assert property (p_sdo_stable) else $error("sdo moved");
  c_frame: cover property ($rose(select_n) && awake);
  c_wake: cover property ($rose(awake));
  c_drive: cover property (|high_side_on);
endmodule // hbsc_chk
`default_nettype wire

// >>> verif/hbsc_spi_master.sv
// SPI master model driving the command link
`timescale 1ns/1ps
`default_nettype none
module hbsc_spi_master
(
  // Link pins
  output var logic select_n,
  output var logic sclk,
  output var logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial
  begin
    select_n = 1'h1;
    sclk = 1'h0;
    sdi = 1'h0;
  end
  // ----------------------------------------------------------------
  // One frame, 200 ns link clock
  // ----------------------------------------------------------------
  task automatic frame(input int n, input logic [31:0] d, output logic pre,
                       output logic [15:0] dg);
    logic v;
    v = 1'h0;
    dg = 16'h0;
    #3.7;
    select_n = 1'h0;
    #300;
    v = sdo_oe ? sdo : ~v;
    pre = v;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = d[i];
      sclk = 1'h1;
      #100;
      sclk = 1'h0;
      #100;
      v = sdo_oe ? sdo : ~v;
      if (n - 1 - i < 16)
        dg[15 - (n - 1 - i)] = v;
    end
    #100;
    select_n = 1'h1;
    sdi = 1'h0;
    #5000;
  endtask
endmodule // hbsc_spi_master
`default_nettype wire

// >>> verif/test_half_bridge_spi_control.sv
// Testbench for the half-bridge SPI control block
`timescale 1ns/1ps
`default_nettype none
module test_half_bridge_spi_control;
  logic        clk, resetn, enable, thermal_shutdown_in, supply_fault_in, thermal_warning_in;
  logic [5:0]  overcurrent_in, underload_in, high_side_on, low_side_on;
  logic        select_n, sclk, sdi, sdo, sdo_oe, awake;
  logic        underload_shutdown_ctrl, overvoltage_lockout_ctrl;
  int          n_mismatch, checked;
  logic [15:0] cmd;
  logic [5:0]  ocq, ulq;
  logic        tsdq, aw;
  realtime     last;
  int          lens [6] = '{15, 17, 23, 24, 32, 20};

  always #12.5 clk = ~clk;

  hbsc_spi_ctrl hbsc_spi_ctrl_i (.clk, .resetn, .select_n, .sclk, .sdi, .sdo, .sdo_oe, .enable,
    .thermal_shutdown_in, .supply_fault_in, .thermal_warning_in, .overcurrent_in, .underload_in,
    .high_side_on, .low_side_on, .underload_shutdown_ctrl, .overvoltage_lockout_ctrl, .awake);
  hbsc_spi_master hbsc_spi_master_i (.select_n, .sclk, .sdi, .sdo, .sdo_oe);
  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] diag();
    logic [15:0] w;
    w = {|ocq, supply_fault_in, |ulq, 12'h0, thermal_warning_in};
    for (int i = 0; i < 6; i++)
      w[2*i+2 -: 2] = ocq[i] ? 2'h1 : ulq[i] ? 2'h2 : cmd[7+i] ? 2'h3 : 2'h0;
    return w;
  endfunction
  function automatic logic [15:0] drv();
    logic [5:0] on;
    on = cmd[12:7] & ~ocq & ~(ulq & {6{cmd[13]}}) & ~{6{tsdq}};
    return {1'h0, aw, cmd[13], cmd[0], on & cmd[6:1], on & ~cmd[6:1]};
  endfunction
  task automatic chk_drv();
    chk({1'h0, awake, underload_shutdown_ctrl, overvoltage_lockout_ctrl, high_side_on,
      low_side_on}, drv());
  endtask
  task automatic xfer(input int n, input logic [31:0] d);
    logic pre;
    logic [15:0] dg, ed, m;
    int q [$];
    ed = diag();
    m = (n >= 16) ? 16'hffff : ~(16'hffff >> n);
    for (int i = n - 1; i >= 0; i--)
      q.push_back(int'(d[i]));
    while (q.size() > 16)
      void'(q.pop_front());
    hbsc_spi_master_i.frame(n, d, pre, dg);
    if (aw)
    begin
      chk({15'h0, pre}, {15'h0, tsdq});
      chk(dg & m, ed & m);
    end
    if (aw && n >= 16 && (n - 16) % 8 == 0)
    begin
      if (q[0] == 1 && $realtime - last >= 150000.0)
        {ocq, ulq, tsdq} = 13'h0;
      foreach (q[i])
        cmd[15 - i] = 1'(q[i]);
    end
    // Spacing only counts frames seen while running
    if (aw)
      last = $realtime;
    chk_drv();
  endtask
  task automatic pulse(input logic [5:0] oc, input logic [5:0] ul, input logic t);
    @(posedge clk);
    overcurrent_in <= oc;
    underload_in <= ul;
    thermal_shutdown_in <= t;
    repeat (4) @(posedge clk);
    overcurrent_in <= 6'h0;
    underload_in <= 6'h0;
    thermal_shutdown_in <= 1'h0;
    repeat (8) @(posedge clk);
    ocq |= oc;
    ulq |= ul;
    tsdq |= t;
  endtask
  task automatic wait_awake();
    int k;
    k = 0;
    while (awake !== 1'h1 && k < 4200)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 4200)
    begin
      n_mismatch++;
      final_report();
    end
    aw = 1'h1;
  endtask
  task automatic final_report();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk, resetn, enable, thermal_shutdown_in, supply_fault_in, thermal_warning_in} = 6'h0;
    {overcurrent_in, underload_in, ocq, ulq, tsdq, aw, cmd} = 42'h0;
    n_mismatch = 0;
    checked = 0;
    last = -1.0e9;
    void'($urandom(41626));
    repeat (8) @(posedge clk);
    chk_drv();
    resetn <= 1'h1;
    enable <= 1'h1;
    supply_fault_in <= 1'($urandom);
    thermal_warning_in <= 1'($urandom);
    xfer(16, 32'h1f80);
    wait_awake();
    repeat (6) xfer(16, $urandom & 32'h3fff);
    foreach (lens[i]) xfer(lens[i], $urandom & 32'hffffbfff);
    xfer(16, 32'h1f80);
    pulse(6'h00, 6'h03, 1'h0);
    pulse(6'h05, 6'h00, 1'h0);
    pulse(6'h00, 6'h04, 1'h0);
    xfer(16, 32'h9ffe);
    xfer(16, 32'h3f80);
    repeat (6200) @(posedge clk);
    xfer(16, 32'h9f81);
    xfer(16, 32'h1f81);
    pulse(6'h00, 6'h00, 1'h1);
    xfer(16, 32'h1f81);
    repeat (6200) @(posedge clk);
    xfer(16, 32'h9f81);
    xfer(16, 32'h1f81);
    enable <= 1'h0;
    repeat (10) @(posedge clk);
    {ocq, ulq, tsdq, aw, cmd} = 30'h0;
    last = -1.0e9;
    chk_drv();
    enable <= 1'h1;
    wait_awake();
    xfer(16, 32'h0550);
    xfer(16, 32'h0000);
    final_report();
  end
endmodule // test_half_bridge_spi_control

bind hbsc_spi_ctrl hbsc_chk hbsc_chk_i (.clk, .resetn, .select_n, .sclk, .enable, .sdo,
  .sdo_oe, .high_side_on, .low_side_on, .underload_shutdown_ctrl, .overvoltage_lockout_ctrl,
  .awake);
`default_nettype wire
